/* File: rtl/dac_port_pkg.sv */
// Operation
// - Shift data in on each serial clock rise while frame sync is low
// - Sixteen-bit word: eight data, eight control bits
// - Frame opens when frame sync falls low
// - Frame sync rise after sixteen bits loads data and control registers
// - Reference select one picks the external reference
// - Accept one sixteen-bit or two eight-bit bursts
// - Data byte is straight binary, MSB first
package dac_port_pkg;

    localparam int         WORD_BITS     = 16;
    localparam int         BYTE_BITS     = 8;
    localparam int         COUNT_BITS    = 5;
    localparam logic [4:0] COUNT_FULL    = 5'h10;
    localparam logic [4:0] COUNT_LAST    = 5'h0F;
    localparam logic [4:0] COUNT_ZERO    = 5'h00;
    localparam int         REF_SEL_POS   = 7;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [2:0] PIPE_RESET_HI = 3'h7;
    localparam logic [2:0] PIPE_RESET_LO = 3'h0;

    // The control byte arrives first, so it sits in the upper half.
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] data;
    } word_t;

    typedef enum logic [0:0] {
        FRAME_IDLE = 1'b0,
        FRAME_OPEN = 1'b1
    } frame_state_t;

endpackage : dac_port_pkg

/* File: rtl/dual_dac_serial_input_port.sv */
`timescale 1ns/1ns
`default_nettype none
module dual_dac_serial_input_port (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       serialClock,
    input  wire logic       serialData,
    input  wire logic       frameSyncN,
    output var  logic [7:0] dacCode,
    output var  logic [7:0] controlByte,
    output var  logic       referenceSelectBit,
    output var  logic       wordLoaded,
    output var  logic       frameActive
);

    // Link side, clocked by the host's serial clock.
    dac_port_pkg::word_t         shiftQ;
    dac_port_pkg::word_t         shiftD;
    logic [4:0]                  countQ;
    logic [4:0]                  countD;
    logic                        fullQ;
    logic                        fullD;
    logic                        countClear;

    // The count is held clear while the frame is closed, so no clock edge
    // is needed between frames to restart it.
    assign countClear = rst | frameSyncN;

    always_comb begin
        shiftD = dac_port_pkg::word_t'({shiftQ[14:0], serialData});
        countD = countQ;
        fullD  = fullQ;
        if (countQ != dac_port_pkg::COUNT_FULL) begin
            countD = countQ + 5'h01;
        end
        if (countQ == dac_port_pkg::COUNT_LAST) begin
            fullD = 1'b1;
        end else if (countQ == dac_port_pkg::COUNT_ZERO) begin
            fullD = 1'b0;
        end
    end

    // The shift register only moves while the frame is open; serial clock
    // edges that come with frame sync high leave it unchanged.
    always_ff @(posedge serialClock or posedge rst) begin
        if (rst) begin
            shiftQ <= '0;
            fullQ  <= 1'b0;
        end else if (!frameSyncN) begin
            shiftQ <= shiftD;
            fullQ  <= fullD;
        end
    end

    always_ff @(posedge serialClock or posedge countClear) begin
        if (countClear) begin
            countQ <= dac_port_pkg::COUNT_ZERO;
        end else begin
            countQ <= countD;
        end
    end

    // System side: pin and cross-domain inputs pass three flip-flops and a
    // change counts once the last two agree.
    logic [2:0]                  syncPipeQ;
    logic [2:0]                  syncPipeD;
    logic [2:0]                  fullPipeQ;
    logic [2:0]                  fullPipeD;
    logic                        syncLevelQ;
    logic                        syncLevelD;
    logic                        fullLevelQ;
    logic                        fullLevelD;
    dac_port_pkg::frame_state_t  stateQ;
    dac_port_pkg::frame_state_t  stateD;
    logic [7:0]                  dataQ;
    logic [7:0]                  dataD;
    logic [7:0]                  controlQ;
    logic [7:0]                  controlD;
    logic                        refQ;
    logic                        refD;
    logic                        loadedQ;
    logic                        loadedD;

    // A level only moves once the last two stages agree, so a sample taken
    // while the far side was switching cannot pass through alone.
    function automatic logic settle(input logic [2:0] pipe, input logic level);
        settle = (pipe[1] == pipe[2]) ? pipe[2] : level;
    endfunction : settle

    always_comb begin
        syncPipeD  = {syncPipeQ[1:0], frameSyncN};
        fullPipeD  = {fullPipeQ[1:0], fullQ};
        syncLevelD = settle(syncPipeQ, syncLevelQ);
        fullLevelD = settle(fullPipeQ, fullLevelQ);
    end

    always_comb begin
        stateD   = stateQ;
        dataD    = dataQ;
        controlD = controlQ;
        refD     = refQ;
        loadedD  = 1'b0;
        unique case (stateQ)
            dac_port_pkg::FRAME_IDLE: begin
                if (!syncLevelQ) begin
                    stateD = dac_port_pkg::FRAME_OPEN;
                end
            end
            dac_port_pkg::FRAME_OPEN: begin
                if (syncLevelQ) begin
                    stateD = dac_port_pkg::FRAME_IDLE;
                    // A frame shorter than sixteen bits leaves the
                    // registers as they were. The shift register is quiet
                    // here because it only shifts while frame sync is low.
                    if (fullLevelQ) begin
                        dataD    = shiftQ.data;
                        controlD = shiftQ.control;
                        refD     = shiftQ.control[dac_port_pkg::REF_SEL_POS];
                        loadedD  = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syncPipeQ  <= dac_port_pkg::PIPE_RESET_HI;
            fullPipeQ  <= dac_port_pkg::PIPE_RESET_LO;
            syncLevelQ <= 1'b1;
            fullLevelQ <= 1'b0;
            stateQ     <= dac_port_pkg::FRAME_IDLE;
            dataQ      <= dac_port_pkg::DATA_RESET;
            controlQ   <= dac_port_pkg::CONTROL_RESET;
            refQ       <= 1'b0;
            loadedQ    <= 1'b0;
        end else if (ce) begin
            syncPipeQ  <= syncPipeD;
            fullPipeQ  <= fullPipeD;
            syncLevelQ <= syncLevelD;
            fullLevelQ <= fullLevelD;
            stateQ     <= stateD;
            dataQ      <= dataD;
            controlQ   <= controlD;
            refQ       <= refD;
            loadedQ    <= loadedD;
        end
    end

    assign dacCode            = dataQ;
    assign controlByte        = controlQ;
    assign referenceSelectBit = refQ;
    assign wordLoaded         = loadedQ;
    assign frameActive        = logic'(stateQ);

endmodule : dual_dac_serial_input_port
`default_nettype wire

/* File: tb/dac_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_host_model (
    output var logic serialClock,
    output var logic serialData,
    output var logic frameSyncN
);
initial begin
    serialClock = 1'b0;
    serialData = 1'b1;
    frameSyncN = 1'b1;
end
// The clock stands still between frames; idle data shows the inverse of its last bit.
task automatic send(input logic [15:0] w, input int n, input bit split);
    frameSyncN = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
        if (split && i == 7) #400;
        serialData = w[i];
        #40 serialClock = 1'b1;
        #40 serialClock = 1'b0;
    end
    #160 frameSyncN = 1'b1;
    serialData = ~serialData;
    #200;
endtask : send
endmodule : dac_host_model
`default_nettype wire

/* File: tb/dac_port_props.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_port_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       frameSyncN,
    input wire logic [7:0] dacCode,
    input wire logic [7:0] controlByte,
    input wire logic       referenceSelectBit,
    input wire logic       wordLoaded,
    input wire logic       frameActive
);
default clocking @(posedge clock); endclocking
default disable iff (rst);
property p_one; wordLoaded |=> !wordLoaded; endproperty
a_one: assert property (p_one) else $error("long load");
property p_ref; referenceSelectBit == controlByte[7]; endproperty
a_ref: assert property (p_ref) else $error("ref bit");
property p_hold; !wordLoaded |-> $stable({dacCode, controlByte}); endproperty
a_hold: assert property (p_hold) else $error("drift");
property p_rise; wordLoaded |-> $past(frameSyncN, 3); endproperty
a_rise: assert property (p_rise) else $error("early load");
property p_open; $fell(frameSyncN) |-> ##[3:6] frameActive; endproperty
a_open: assert property (p_open) else $error("no open");
property p_low; $rose(frameActive) |-> !$past(frameSyncN, 3); endproperty
a_low: assert property (p_low) else $error("bad open");
property p_idle; frameActive |-> !wordLoaded; endproperty
a_idle: assert property (p_idle) else $error("mid load");
property p_done; $rose(frameSyncN) && frameActive |-> ##[3:6] !frameActive; endproperty
a_done: assert property (p_done) else $error("no close");
endmodule : dac_port_props
bind dual_dac_serial_input_port dac_port_props u_props (.clock(clock), .rst(rst),
    .frameSyncN(frameSyncN), .dacCode(dacCode), .controlByte(controlByte),
    .referenceSelectBit(referenceSelectBit), .wordLoaded(wordLoaded), .frameActive(frameActive));
`default_nettype wire

/* File: tb/dual_dac_serial_input_port_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module dual_dac_serial_input_port_bench;
logic clock = 1'b0, rst, ce = 1'b1, serialClock, serialData, frameSyncN;
logic [7:0] dacCode, controlByte;
logic referenceSelectBit, wordLoaded, frameActive;
int fails = 0, checksDone = 0;
logic [15:0] w;
dac_port_pkg::word_t expQ[$], e;
initial forever #10 clock = ~clock;
dual_dac_serial_input_port DUT (.clock(clock), .rst(rst), .ce(ce),
    .serialClock(serialClock), .serialData(serialData), .frameSyncN(frameSyncN),
    .dacCode(dacCode), .controlByte(controlByte), .referenceSelectBit(referenceSelectBit),
    .wordLoaded(wordLoaded), .frameActive(frameActive));
dac_host_model host (.serialClock(serialClock), .serialData(serialData),
    .frameSyncN(frameSyncN));
task automatic complete_run;
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask : complete_run
always @(negedge clock) if (wordLoaded === 1'b1) begin
    checksDone++;
    e = (expQ.size() > 0) ? expQ.pop_front() : 16'hXXXX;
    if ({controlByte, dacCode} !== e || referenceSelectBit !== e.control[dac_port_pkg::REF_SEL_POS]) begin
        fails++;
        $display("CHECK FAILED %0t word %h", $time, {controlByte, dacCode});
    end
end
initial begin
    rst = 1'b1;
    w = 16'($urandom(32'h3692));
    repeat (5) @(posedge clock);
    #2 rst = 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
        w = 16'($urandom);
        w[15] = i[0];
        expQ.push_back(w);
        fork
            host.send(w, 16, i[1]);
            if (i == 5) begin
                repeat (20) @(posedge clock);
                #2 ce = 1'b0;
                repeat (4) @(posedge clock);
                checksDone++;
                if (frameActive !== 1'b1) begin
                    fails++;
                    $display("CHECK FAILED %0t frozen frame lost", $time);
                end
                #2 ce = 1'b1;
            end
        join
        $display("test %0d done", i);
    end
    host.send(16'h1234, 9, 1'b0);
    $display("test short frame done");
    expQ.push_back(16'h80FF);
    host.send(16'h80FF, 16, 1'b0);
    repeat (10) @(posedge clock);
    $display("test full scale done");
    checksDone++;
    if (expQ.size() != 0) begin
        fails++;
        $display("CHECK FAILED %0t missing load", $time);
    end
    complete_run();
end
initial begin
    #100000;
    fails++;
    $display("CHECK FAILED %0t timeout", $time);
    complete_run();
end
endmodule : dual_dac_serial_input_port_bench
`default_nettype wire
